//--- src/vdm_pkg.sv
// Shared field layout, codes and register map for mode entry/exit messaging
package vdm_pkg;

  // ----------------------------------------------------------------
  // Message header layout and codes
  // ----------------------------------------------------------------
  localparam int       HDR_TYPE_LSB = 0;
  localparam int       HDR_REV_LSB  = 6;
  localparam int       HDR_ROLE_BIT = 8;
  localparam int       HDR_ID_LSB   = 9;
  localparam int       HDR_CNT_LSB  = 12;
  localparam logic [3:0] MSG_TYPE_VDM = 4'hF;
  localparam logic [1:0] SPEC_REV     = 2'h1;
  localparam logic [2:0] NUM_OBJ_ONE  = 3'h1;

  // ----------------------------------------------------------------
  // VDM header layout and codes
  // ----------------------------------------------------------------
  localparam int       VDM_CMD_LSB    = 0;
  localparam int       VDM_SRC_BIT    = 5;
  localparam int       VDM_CT_LSB     = 6;
  localparam int       VDM_POS_LSB    = 8;
  localparam int       VDM_VER_LSB    = 13;
  localparam int       VDM_STRUCT_BIT = 15;
  localparam int       VDM_SVID_LSB   = 16;
  localparam logic [1:0] SVDM_VER     = 2'h0;
  localparam logic [1:0] CT_REQ       = 2'h0;
  localparam logic [1:0] CT_ACK       = 2'h1;
  localparam logic [1:0] CT_NAK       = 2'h2;
  localparam logic [4:0] CMD_ENTER    = 5'h04;
  localparam logic [4:0] CMD_EXIT     = 5'h05;

  // ----------------------------------------------------------------
  // Controller register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_TARGET = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [15:0] SVID_RST    = 16'h0000;
  localparam logic [2:0]  POS_RST     = 3'h1;
  localparam int          CMD_ENTER_BIT  = 0;
  localparam int          CMD_EXIT_BIT   = 1;
  localparam int          TGT_POS_LSB    = 16;
  localparam int          ST_BUSY_BIT    = 0;
  localparam int          ST_DONE_BIT    = 1;
  localparam int          ST_ACK_BIT     = 2;
  localparam int          ST_REFUSED_BIT = 3;
  localparam int          ST_ACTIVE_BIT  = 4;
  localparam int          ST_POS_LSB     = 8;
  localparam int          ST_SVID_LSB    = 16;

endpackage : vdm_pkg

//--- src/vdm_link.sv
// Message link joining mode initiator and mode responder
`timescale 1ns/1ps
`default_nettype none
interface vdm_link;
  // Request from initiator, one-cycle valid pulse
  logic        req_valid;
  logic [15:0] req_hdr;
  logic [31:0] req_vdm;
  // Answer from responder, one-cycle valid pulse
  logic        rsp_valid;
  logic [15:0] rsp_hdr;
  logic [31:0] rsp_vdm;

  modport init (output req_valid, output req_hdr, output req_vdm,
                input rsp_valid, input rsp_hdr, input rsp_vdm);
  modport resp (input req_valid, input req_hdr, input req_vdm,
                output rsp_valid, output rsp_hdr, output rsp_vdm);
endinterface : vdm_link
`default_nettype wire

//--- src/vdm_frame.sv
// Builds outgoing headers and decodes incoming ones for a single-object VDM
`timescale 1ns/1ps
`default_nettype none
module vdm_frame
  import vdm_pkg::*;
(
  // Fields to send
  input  wire logic [2:0]  tx_id,
  input  wire logic        tx_role,
  input  wire logic [15:0] tx_svid,
  input  wire logic [2:0]  tx_pos,
  input  wire logic [1:0]  tx_ct,
  input  wire logic        tx_src,
  input  wire logic [4:0]  tx_cmd,
  output logic      [15:0] tx_hdr,
  output logic      [31:0] tx_vdm,
  // Received words and their fields
  input  wire logic [15:0] rx_hdr,
  input  wire logic [31:0] rx_vdm,
  output logic             rx_ok,
  output logic      [15:0] rx_svid,
  output logic      [2:0]  rx_pos,
  output logic      [1:0]  rx_ct,
  output logic      [4:0]  rx_cmd
);

  // ----------------------------------------------------------------
  // Transmit: reserved bits forced to zero
  // ----------------------------------------------------------------
  assign tx_hdr = {1'b0, NUM_OBJ_ONE, tx_id, tx_role, SPEC_REV, 2'h0,
                   MSG_TYPE_VDM};
  assign tx_vdm = {tx_svid, 1'b1, SVDM_VER, 2'h0, tx_pos, tx_ct,
                   tx_src, tx_cmd};

  // ----------------------------------------------------------------
  // Receive: reserved bits and source bit are not looked at
  // ----------------------------------------------------------------
  assign rx_ok   = (rx_hdr[HDR_TYPE_LSB +: 4] == MSG_TYPE_VDM)
                 & (rx_hdr[HDR_CNT_LSB +: 3] == NUM_OBJ_ONE)
                 & (rx_hdr[HDR_REV_LSB +: 2] == SPEC_REV)
                 & rx_vdm[VDM_STRUCT_BIT]
                 & (rx_vdm[VDM_VER_LSB +: 2] == SVDM_VER);
  assign rx_svid = rx_vdm[VDM_SVID_LSB +: 16];
  assign rx_pos  = rx_vdm[VDM_POS_LSB +: 3];
  assign rx_ct   = rx_vdm[VDM_CT_LSB +: 2];
  assign rx_cmd  = rx_vdm[VDM_CMD_LSB +: 5];

endmodule : vdm_frame
`default_nettype wire

//--- src/mode_responder.sv
// Responder end: answers mode entry and exit requests and tracks the mode
`timescale 1ns/1ps
`default_nettype none
module mode_responder
  import vdm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // Link
  vdm_link.resp            link,
  // Port role and the modes offered by this port
  input  wire logic        power_role,
  input  wire logic [15:0] mode_svid,
  input  wire logic [2:0]  mode_count,
  // Mode state
  output logic             mode_active,
  output logic [15:0]      active_svid,
  output logic [2:0]       active_pos
);

  logic        rsp_valid_q;
  logic [15:0] rsp_hdr_q;
  logic [31:0] rsp_vdm_q;
  logic [2:0]  msg_id_q;
  logic        active_q;
  logic [15:0] act_svid_q;
  logic [2:0]  act_pos_q;
  logic        rx_ok;
  logic [15:0] rx_svid;
  logic [2:0]  rx_pos;
  logic [1:0]  rx_ct;
  logic [4:0]  rx_cmd;
  logic [15:0] tx_hdr;
  logic [31:0] tx_vdm;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire is_req   = link.req_valid & rx_ok & (rx_ct == CT_REQ);
  wire is_enter = is_req & (rx_cmd == CMD_ENTER);
  wire is_exit  = is_req & (rx_cmd == CMD_EXIT);
  // Offset must name one of the offered modes; zero names none
  wire enter_ok = is_enter & (rx_svid == mode_svid) & (rx_pos != 3'h0)
                & (rx_pos <= mode_count);
  wire exit_ok  = is_exit & active_q & (rx_svid == act_svid_q)
                & (rx_pos == act_pos_q);
  wire answer   = is_enter | is_exit;
  wire [1:0] ans_ct = (enter_ok | exit_ok) ? CT_ACK : CT_NAK;

  // Answer echoes the requested SVID and offset, source bit set
  vdm_frame u_frame (
    .tx_id   (msg_id_q),
    .tx_role (power_role),
    .tx_svid (rx_svid),
    .tx_pos  (rx_pos),
    .tx_ct   (ans_ct),
    .tx_src  (1'b1),
    .tx_cmd  (rx_cmd),
    .tx_hdr  (tx_hdr),
    .tx_vdm  (tx_vdm),
    .rx_hdr  (link.req_hdr),
    .rx_vdm  (link.req_vdm),
    .rx_ok   (rx_ok),
    .rx_svid (rx_svid),
    .rx_pos  (rx_pos),
    .rx_ct   (rx_ct),
    .rx_cmd  (rx_cmd)
  );

  // Answer register, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_hdr_q   <= 16'h0000;
      rsp_vdm_q   <= 32'h00000000;
      msg_id_q    <= 3'h0;
    end else if (ce) begin
      rsp_valid_q <= answer;
      if (answer) begin
        rsp_hdr_q <= tx_hdr;
        rsp_vdm_q <= tx_vdm;
        msg_id_q  <= msg_id_q + 3'h1;
      end
    end
  end

  // Mode state; an exit returns the port to normal operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q   <= 1'b0;
      act_svid_q <= 16'h0000;
      act_pos_q  <= 3'h0;
    end else if (ce) begin
      if (enter_ok) begin
        active_q   <= 1'b1;
        act_svid_q <= rx_svid;
        act_pos_q  <= rx_pos;
      end else if (exit_ok) begin
        active_q   <= 1'b0;
      end
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_hdr   = rsp_hdr_q;
  assign link.rsp_vdm   = rsp_vdm_q;
  assign mode_active    = active_q;
  assign active_svid    = act_svid_q;
  assign active_pos     = act_pos_q;

endmodule : mode_responder
`default_nettype wire

//--- src/mode_initiator.sv
// Initiator end: APB-controlled sender of mode entry and exit requests
`timescale 1ns/1ps
`default_nettype none
module mode_initiator
  import vdm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Link
  vdm_link.init                  link,
  // Port role and progress
  input  wire logic              power_role,
  output logic                   busy,
  output logic                   mode_active
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W must be at least 4");
  end

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WAIT
  } state_t;

  state_t      state_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [15:0] svid_q;
  logic [2:0]  pos_q;
  logic [4:0]  cmd_q;
  logic [2:0]  msg_id_q;
  logic        req_valid_q;
  logic        busy_q;
  logic [15:0] req_hdr_q;
  logic [31:0] req_vdm_q;
  logic        done_q;
  logic        ack_q;
  logic        refused_q;
  logic        active_q;
  logic [15:0] act_svid_q;
  logic [2:0]  act_pos_q;
  logic [15:0] tx_hdr;
  logic [31:0] tx_vdm;
  logic        rx_ok;
  logic [15:0] rx_svid;
  logic [2:0]  rx_pos;
  logic [1:0]  rx_ct;
  logic [4:0]  rx_cmd;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Access cycle before the answer, and the edge a write takes effect
  wire acc      = psel & penable & ~pready_q;
  wire wr_take  = psel & penable & pready_q & pwrite;
  wire sel_cmd  = (paddr == ADDR_W'(ADDR_CMD));
  wire sel_tgt  = (paddr == ADDR_W'(ADDR_TARGET));
  wire sel_st   = (paddr == ADDR_W'(ADDR_STATUS));
  wire hit      = sel_cmd | sel_tgt | sel_st;

  // Status word: progress, outcome and the mode currently held
  wire [31:0] status_word = {act_svid_q, 5'h00, act_pos_q, 3'h0,
                             active_q, refused_q, ack_q, done_q,
                             (state_q == ST_WAIT)};
  wire [31:0] target_word = {13'h0, pos_q, svid_q};
  wire [31:0] rd_mux = sel_tgt ? target_word :
                       sel_st  ? status_word : 32'h00000000;

  // Commands are refused silently while a request is outstanding
  wire go_enter = wr_take & sel_cmd & pwdata[CMD_ENTER_BIT]
                & (state_q == ST_IDLE);
  wire go_exit  = wr_take & sel_cmd & pwdata[CMD_EXIT_BIT]
                & ~pwdata[CMD_ENTER_BIT] & (state_q == ST_IDLE);
  wire go       = go_enter | go_exit;
  wire [4:0] go_cmd = go_enter ? CMD_ENTER : CMD_EXIT;
  wire clr_done = wr_take & sel_st & pwdata[ST_DONE_BIT];

  // ----------------------------------------------------------------
  // Frame build and answer decode
  // ----------------------------------------------------------------
  vdm_frame u_frame (
    .tx_id   (msg_id_q),
    .tx_role (power_role),
    .tx_svid (svid_q),
    .tx_pos  (pos_q),
    .tx_ct   (CT_REQ),
    .tx_src  (1'b0),
    .tx_cmd  (go_cmd),
    .tx_hdr  (tx_hdr),
    .tx_vdm  (tx_vdm),
    .rx_hdr  (link.rsp_hdr),
    .rx_vdm  (link.rsp_vdm),
    .rx_ok   (rx_ok),
    .rx_svid (rx_svid),
    .rx_pos  (rx_pos),
    .rx_ct   (rx_ct),
    .rx_cmd  (rx_cmd)
  );

  // Answer must match what was asked: same command, SVID, offset
  wire got_rsp = (state_q == ST_WAIT) & link.rsp_valid;
  wire rsp_match = rx_ok & (rx_cmd == cmd_q)
                 & (rx_svid == svid_q)
                 & (rx_pos == pos_q);
  wire rsp_acked = rsp_match & (rx_ct == CT_ACK);

  // ----------------------------------------------------------------
  // APB answer, registered: ready comes one cycle into access
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= acc;
      prdata_q  <= (acc & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr_q <= acc & ~hit;
    end
  end

  // Target register: SVID and offset of the mode to enter or leave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svid_q <= SVID_RST;
      pos_q  <= POS_RST;
    end else if (ce && wr_take && sel_tgt && state_q == ST_IDLE) begin
      svid_q <= pwdata[15:0];
      pos_q  <= pwdata[TGT_POS_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Request sequencer
  // ----------------------------------------------------------------
  // Request is a one-cycle pulse; no timeout, software sees busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_IDLE;
      cmd_q       <= 5'h00;
      msg_id_q    <= 3'h0;
      req_valid_q <= 1'b0;
      busy_q      <= 1'b0;
      req_hdr_q   <= 16'h0000;
      req_vdm_q   <= 32'h00000000;
    end else if (ce) begin
      req_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            req_valid_q <= 1'b1;
            busy_q      <= 1'b1;
            req_hdr_q   <= tx_hdr;
            req_vdm_q   <= tx_vdm;
            cmd_q       <= go_cmd;
            msg_id_q    <= msg_id_q + 3'h1;
            state_q     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (got_rsp) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outcome flags; a finishing answer beats a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q    <= 1'b0;
      ack_q     <= 1'b0;
      refused_q <= 1'b0;
    end else if (ce) begin
      if (got_rsp) begin
        done_q    <= 1'b1;
        ack_q     <= rsp_acked;
        refused_q <= ~rsp_acked;
      end else if (go) begin
        done_q    <= 1'b0;
        ack_q     <= 1'b0;
        refused_q <= 1'b0;
      end else if (clr_done) begin
        done_q <= 1'b0;
      end
    end
  end

  // Mode held at the far end as seen from acknowledged answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q   <= 1'b0;
      act_svid_q <= 16'h0000;
      act_pos_q  <= 3'h0;
    end else if (ce && got_rsp && rsp_acked) begin
      if (cmd_q == CMD_ENTER) begin
        active_q   <= 1'b1;
        act_svid_q <= rx_svid;
        act_pos_q  <= rx_pos;
      end else begin
        active_q   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign link.req_valid = req_valid_q;
  assign link.req_hdr   = req_hdr_q;
  assign link.req_vdm   = req_vdm_q;
  assign busy           = busy_q;
  assign mode_active    = active_q;

endmodule : mode_initiator
`default_nettype wire

//--- tb/vdm_link_monitor.sv
// Concurrent checks on the mode entry and exit message link
`timescale 1ns/1ps
`default_nettype none
module vdm_link_monitor
  import vdm_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Request words
  input wire logic        req_valid,
  input wire logic [15:0] req_hdr,
  input wire logic [31:0] req_vdm,
  // Answer words
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_hdr,
  input wire logic [31:0] rsp_vdm
);
  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MSG_TYPE: assert property ((req_valid || rsp_valid) |->
    (!req_valid || req_hdr[3:0] == 4'hF) && (!rsp_valid || rsp_hdr[3:0] == 4'hF))
    else $error("message type field wrong");
  AST_REQ_HDR: assert property (req_valid |->
    req_hdr[15:12] == 4'h1 && req_hdr[7:4] == 4'h4) else $error("request header wrong");
  AST_RSP_HDR: assert property (rsp_valid |->
    rsp_hdr[15:12] == 4'h1 && rsp_hdr[7:4] == 4'h4) else $error("answer header wrong");
  AST_REQ_VDM: assert property (req_valid |->
    req_vdm[15:11] == 5'h10 && req_vdm[7:5] == 3'h0 &&
    (req_vdm[4:0] == CMD_ENTER || req_vdm[4:0] == CMD_EXIT))
    else $error("request VDM header wrong");
  AST_RSP_VDM: assert property (rsp_valid |->
    rsp_vdm[15:11] == 5'h10 && rsp_vdm[5]) else $error("answer VDM header wrong");
  AST_ANSWER_TIME: assert property (req_valid |=> rsp_valid)
    else $error("answer missing one cycle after request");
  AST_NO_STRAY: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  AST_ECHO: assert property (rsp_valid |->
    rsp_vdm[31:16] == $past(req_vdm[31:16]) && rsp_vdm[10:8] == $past(req_vdm[10:8]) &&
    rsp_vdm[4:0] == $past(req_vdm[4:0])) else $error("answer does not echo request");
  // Words must hold between requests so late readers see the same frame
  AST_REQ_HOLD: assert property (!req_valid |-> $stable(req_hdr) && $stable(req_vdm))
    else $error("request words moved while idle");
endmodule : vdm_link_monitor
`default_nettype wire

//--- tb/structured_vdm_mode_enter_exit_test.sv
// Testbench joining initiator and responder, with a fault-driven spare responder
`timescale 1ns/1ps
`default_nettype none
module structured_vdm_mode_enter_exit_test;
  import vdm_pkg::*;
  // ----------------------------------------------------------------
  // Signals and state
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        role_i, role_r, busy, act_i, act_r, act;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] msvid, bad, asv, asvid_r;
  logic [2:0]  apos, apos_r;
  logic [47:0] rq;
  logic [64:0] apb_q[$];
  logic [95:0] link_q[$];
  logic [95:0] note;
  int          error_cnt, num_checks;
  vdm_link link();
  vdm_link link2();

  mode_initiator mode_initiator_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link), .power_role(role_i), .busy(busy),
    .mode_active(act_i));
  mode_responder mode_responder_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(link),
    .power_role(role_r), .mode_svid(msvid), .mode_count(3'h3), .mode_active(act_r),
    .active_svid(asvid_r), .active_pos(apos_r));
  // Spare responder fed frames that break the request format
  mode_responder mode_responder_i2 (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(link2),
    .power_role(role_r), .mode_svid(msvid), .mode_count(3'h3), .mode_active(),
    .active_svid(), .active_pos());
  vdm_link_monitor vdm_link_monitor_i (.pclk(pclk), .presetn(presetn),
    .req_valid(link.req_valid), .req_hdr(link.req_hdr), .req_vdm(link.req_vdm),
    .rsp_valid(link.rsp_valid), .rsp_hdr(link.rsp_hdr), .rsp_vdm(link.rsp_vdm));

  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check

  task wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // One APB transfer; the note holds mask, expected error and data
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] ed, input logic [31:0] m, input logic ee);
    apb_q.push_back({m, ee, ed & m});
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Program target, issue the command, follow the answer and status
  task mode_cmd(input logic ex, input logic [15:0] sv, input logic [2:0] ps);
    logic ok;
    logic [4:0] c;
    logic [15:0] h;
    int n;
    c = ex ? CMD_EXIT : CMD_ENTER;
    ok = ex ? (act && sv == asv && ps == apos) : (sv == msvid && ps >= 3'h1 && ps <= 3'h3);
    h = {4'h1, 3'h0, role_i, 8'h4F};
    link_q.push_back({h, sv, 5'h10, ps, CT_REQ, 1'b0, c, h[15:9], role_r, h[7:0],
                      sv, 5'h10, ps, ok ? CT_ACK : CT_NAK, 1'b1, c});
    apb(1'b1, ADDR_TARGET, {13'h0, ps, sv}, 32'h0, '1, 1'b0);
    apb(1'b1, ADDR_CMD, ex ? 32'h2 : 32'h1, 32'h0, '1, 1'b0);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n == 1) check(96'(busy), 96'(1'b1));
    end while ((busy !== 1'b0 || n < 3) && n < 40);
    if (busy !== 1'b0) error_cnt++;
    if (ok) act = !ex;
    if (ok && !ex) {asv, apos} = {sv, ps};
    check({act_i, act_r}, {act, act});
    if (act) check({asvid_r, apos_r}, {asv, apos});
    apb(1'b0, ADDR_STATUS, 32'h0, {asv, 5'h0, apos, 3'h0, act, !ok, ok, 2'h2},
        act ? 32'hFFFF_FFFF : 32'h0000_00FF, 1'b0);
  endtask : mode_cmd

  // ----------------------------------------------------------------
  // Result watchers: oldest note against each answer seen
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note[64:0] = apb_q.pop_front();
      check({pslverr, prdata & note[64:33]}, {note[32], note[31:0]});
    end
    if (link.req_valid === 1'b1) rq = {link.req_hdr & 16'hF1FF, link.req_vdm};
    if (link.rsp_valid === 1'b1) begin
      note = link_q.pop_front();
      check({rq, link.rsp_hdr & 16'hF1FF, link.rsp_vdm}, note);
    end
  end

  // Watchdog: the whole run needs a few hundred cycles; the limit is 20000 cycles
  initial begin
    #80000;
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [15:0] hs[6];
    logic [31:0] vs[6];
    logic        an[6];
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    link2.req_valid = 0; link2.req_hdr = 0; link2.req_vdm = 0;
    error_cnt = 0; num_checks = 0; act = 0; asv = 0; apos = 0; rq = 0;
    void'($urandom(32'h1e151855));
    msvid = 16'($urandom);
    bad = msvid ^ (16'($urandom) | 16'h1);
    role_i = 1'($urandom);
    role_r = 1'($urandom);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped places and the command register
    apb(1'b0, ADDR_TARGET, 32'h0, {13'h0, POS_RST, SVID_RST}, '1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, '1, 1'b0);
    apb(1'b0, ADDR_CMD, 32'h0, 32'h0, '1, 1'b0);
    apb(1'b0, 12'h00C, 32'h0, 32'h0, '1, 1'b1);
    apb(1'b1, 12'h010, 32'h5, 32'h0, '1, 1'b1);
    // Refusals for no mode, a wrong SVID and the offset boundaries, then a real entry and exit
    mode_cmd(1'b1, msvid, 3'h1);
    mode_cmd(1'b0, bad, 3'h1);
    mode_cmd(1'b0, msvid, 3'h0);
    mode_cmd(1'b0, msvid, 3'h4);
    mode_cmd(1'b0, msvid, 3'h3);
    mode_cmd(1'b1, msvid, 3'h2);
    mode_cmd(1'b1, msvid, 3'h3);
    mode_cmd(1'b0, msvid, 3'h1);
    // Done flag is cleared by writing one
    apb(1'b1, ADDR_STATUS, 32'h2, 32'h0, '1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, {msvid, 8'h1, 8'h14}, '1, 1'b0);
    repeat (8) mode_cmd(1'($urandom), ($urandom % 2) ? msvid : bad, 3'($urandom));
    // Spare link: reserved bits ignored, malformed frames get no answer
    hs = '{16'h104F | 16'h8030, 16'h104F, 16'h204F, 16'h104F, 16'h104E, 16'h104F};
    vs = '{{msvid, 16'h8104} | 32'h1820, {msvid, 16'h8144}, {msvid, 16'h8104},
           {msvid, 16'h8103}, {msvid, 16'h8104}, {msvid, 16'h0104}};
    an = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      link2.req_valid <= 1'b1; link2.req_hdr <= hs[i]; link2.req_vdm <= vs[i];
      @(posedge pclk);
      link2.req_valid <= 1'b0;
      @(posedge pclk);
      check(96'(link2.rsp_valid), 96'(an[i]));
    end
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule : structured_vdm_mode_enter_exit_test
`default_nettype wire
